// *** rsm_reset_sequence_manager.sv ***
// Reset source merge, three-phase reset sequencer, cause flags and option settings
`timescale 1ns/100ps
`include "rsm_regs.svh"
// Functional notes
// - Hold reset while the supply stays below the detector threshold.
// - Detector releases at a higher point than it trips.
// - Drive the reset pin low during a brownout reset.
// - Brownout flag set by hardware, cleared only by writing zero.
// - All three sources act on the pin; pin low through delay phase.
// - Sequence ends fetching the vector at FFFE then FFFF.
// - Phases run in order: source delay, 4096-cycle wait, vector fetch.
// - Vector fetch lasts exactly two cycles before execution.
// - External pin low is caught asynchronously, even without clock.
// - After an external pulse, drive the pin low for the output width.
// - Watchdog underflow drives the pin low for the output width.
// - Reset pin is input plus open-drain output, pulled up weakly.
// - Option selects external, four crystal ranges, external or internal RC.
// - Crystal oscillators keep running through the reset phase.
// - Option selects one of three detector levels.
// - Option enables or disables the clock safety unit.
// - Watchdog flag set on watchdog reset; cleared by zero write or brownout.
// - Brownout flag survives later external or watchdog resets.
module rsm_reset_sequence_manager (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register bus
   input wire rsm_pkg::rsm_axil_req_t axil_req,
   output rsm_pkg::rsm_axil_rsp_t axil_rsp,
   // Supply sense and watchdog
   input wire logic [7:0] vdd_level,
   input wire logic wdg_underflow,
   // Reset pin, open drain
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe_n,
   // Core side
   output logic core_reset,
   output logic vector_fetch,
   output logic [15:0] fetch_addr,
   // Clock system controls and detector status
   output rsm_pkg::rsm_osc_t osc_select,
   output logic osc_run,
   output logic css_enable,
   output logic brownout
);
   rsm_pkg::rsm_state_t state, next_state;
   rsm_pkg::rsm_osc_t next_osc_select;
   rsm_pkg::rsm_lvd_level_t lvd_level, next_lvd_level;
   rsm_pkg::rsm_reg_wr_t wr;
   logic [12:0] cnt, next_cnt;
   logic [15:0] next_fetch_addr;
   logic bo_flag, next_bo_flag, wdg_flag, next_wdg_flag;
   logic next_css_enable;
   logic ext_seen, drive_d1, ext_req, any_src, pin_drive;
   logic wr_flags, wr_option, sw_clr_bo, sw_clr_wdg;
   logic wr_ok, rd_ok;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic is_xtal;

   // Bus front end
   rsm_axil u_axil (
      .clk(clk),
      .srst(srst),
      .req(axil_req),
      .rsp(axil_rsp),
      .wr(wr),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // Supply detector at the level chosen by option
   rsm_lvd u_lvd (
      .clk(clk),
      .srst(srst),
      .vdd_level(vdd_level),
      .level(lvd_level),
      .brownout(brownout)
   );

   // Open-drain pin: only ever pulls low, pull-up is on the board side
   always_comb begin
      pin_drive = (state == rsm_pkg::RSM_ST_DELAY);
      rst_pin_out = 1'b0;
      rst_pin_oe_n = !pin_drive;
   end

   // External pulse catcher: a low pin sets it with no clock needed
   always_ff @(posedge clk or negedge rst_pin_in) begin
      if (!rst_pin_in) ext_seen <= 1'b1;
      else ext_seen <= 1'b0;
   end

   // Own drive loops back on the pin, so ignore the catcher while driving
   // and one cycle after, until the released pin has been resampled
   always_ff @(posedge clk) begin
      if (srst) drive_d1 <= 1'b0;
      else drive_d1 <= pin_drive;
   end

   // Merged reset sources
   always_comb begin
      ext_req = ext_seen && !pin_drive && !drive_d1;
      any_src = brownout || wdg_underflow || ext_req;
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      next_cnt = 13'(cnt + 13'h0001);
      next_fetch_addr = fetch_addr;
      if (any_src) begin
         // Any new source restarts everything, stabilisation included
         next_state = rsm_pkg::RSM_ST_DELAY;
         next_cnt = 13'h0000;
      end else begin
         case (state)
            rsm_pkg::RSM_ST_DELAY: begin
               if (cnt >= 13'(`RSM_RSTL_OUT_CYC - 1)) begin
                  next_state = rsm_pkg::RSM_ST_STAB;
                  next_cnt = 13'h0000;
               end
            end
            rsm_pkg::RSM_ST_STAB: begin
               if (cnt == 13'(`RSM_STAB_CYC - 1)) begin
                  next_state = rsm_pkg::RSM_ST_FETCH;
                  next_cnt = 13'h0000;
                  next_fetch_addr = `RSM_VECTOR_ADDR;
               end
            end
            rsm_pkg::RSM_ST_FETCH: begin
               next_fetch_addr = 16'(`RSM_VECTOR_ADDR + 16'h0001);
               if (cnt == 13'(`RSM_FETCH_CYC - 1)) begin
                  next_state = rsm_pkg::RSM_ST_RUN;
                  next_cnt = 13'h0000;
               end
            end
            rsm_pkg::RSM_ST_RUN: begin
               next_cnt = 13'h0000;
            end
            default: begin
               next_state = rsm_pkg::RSM_ST_DELAY;
               next_cnt = 13'h0000;
            end
         endcase
      end
   end

   // Sequencer registers; a bus reset starts a full power-on style sequence
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= rsm_pkg::RSM_ST_DELAY;
         cnt <= 13'h0000;
         fetch_addr <= 16'h0000;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         fetch_addr <= next_fetch_addr;
      end
   end

   // Core side status
   always_comb begin
      core_reset = (state != rsm_pkg::RSM_ST_RUN);
      vector_fetch = (state == rsm_pkg::RSM_ST_FETCH);
   end

   // Register decode
   always_comb begin
      wr_flags = wr.en && wr.addr == `RSM_ADDR_FLAGS && wr.strb[0];
      wr_option = wr.en && wr.addr == `RSM_ADDR_OPTION;
      sw_clr_bo = wr_flags && !wr.data[`RSM_BIT_BO];
      sw_clr_wdg = wr_flags && !wr.data[`RSM_BIT_WDG];
      wr_ok = wr.addr == `RSM_ADDR_FLAGS || wr.addr == `RSM_ADDR_OPTION
         || wr.addr == `RSM_ADDR_STATE;
      rd_ok = rd_addr == `RSM_ADDR_FLAGS || rd_addr == `RSM_ADDR_OPTION
         || rd_addr == `RSM_ADDR_STATE;
      rd_data = 32'h0000_0000;
      case (rd_addr)
         `RSM_ADDR_FLAGS: begin
            rd_data[`RSM_BIT_BO] = bo_flag;
            rd_data[`RSM_BIT_WDG] = wdg_flag;
         end
         `RSM_ADDR_OPTION: begin
            rd_data[`RSM_OPT_OSC_LSB +: 3] = osc_select;
            rd_data[`RSM_OPT_LVL_LSB +: 2] = lvd_level;
            rd_data[`RSM_OPT_CSS_BIT] = css_enable;
         end
         `RSM_ADDR_STATE: begin
            rd_data[1:0] = state;
            rd_data[2] = pin_drive;
            rd_data[3] = brownout;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Cause flags: hardware set wins over a same-cycle software clear
   always_comb begin
      next_bo_flag = bo_flag;
      next_wdg_flag = wdg_flag;
      if (sw_clr_bo) next_bo_flag = 1'b0;
      if (brownout) next_bo_flag = 1'b1;
      if (sw_clr_wdg || brownout) next_wdg_flag = 1'b0;
      if (wdg_underflow) next_wdg_flag = 1'b1;
   end

   // Option settings, written by software at any time in place of option bytes
   always_comb begin
      next_osc_select = osc_select;
      next_lvd_level = lvd_level;
      next_css_enable = css_enable;
      if (wr_option && wr.strb[0]) begin
         next_osc_select = rsm_pkg::rsm_osc_t'(wr.data[`RSM_OPT_OSC_LSB +: 3]);
         next_lvd_level = rsm_pkg::rsm_lvd_level_t'(wr.data[`RSM_OPT_LVL_LSB +: 2]);
      end
      if (wr_option && wr.strb[1]) next_css_enable = wr.data[`RSM_OPT_CSS_BIT];
   end

   // Flag and option registers
   always_ff @(posedge clk) begin
      if (srst) begin
         bo_flag <= 1'b0;
         wdg_flag <= 1'b0;
         osc_select <= rsm_pkg::rsm_osc_t'(`RSM_OPT_OSC_RST);
         lvd_level <= rsm_pkg::rsm_lvd_level_t'(`RSM_OPT_LVL_RST);
         css_enable <= `RSM_OPT_CSS_RST;
      end else begin
         bo_flag <= next_bo_flag;
         wdg_flag <= next_wdg_flag;
         osc_select <= next_osc_select;
         lvd_level <= next_lvd_level;
         css_enable <= next_css_enable;
      end
   end

   // Crystals never stop, saving their slow start-up; RC types may idle
   // while the pin is held low and restart for the stabilisation wait
   always_comb begin
      is_xtal = osc_select == rsm_pkg::RSM_OSC_XTAL0 || osc_select == rsm_pkg::RSM_OSC_XTAL1
         || osc_select == rsm_pkg::RSM_OSC_XTAL2 || osc_select == rsm_pkg::RSM_OSC_XTAL3;
      osc_run = is_xtal || !pin_drive;
   end

   // Sequencer, pin, flag and option checks; a restart may cut any phase short

   AST_LVD_HOLD: assert property (@(posedge clk) disable iff (srst)
      brownout |=> state == rsm_pkg::RSM_ST_DELAY && cnt == 13'h0000)
      else $error("brownout did not hold the sequence in delay");

   AST_LVD_PIN: assert property (@(posedge clk) disable iff (srst)
      brownout |=> !rst_pin_oe_n && !core_reset == 1'b0)
      else $error("pin not pulled low during brownout");

   AST_BO_FLAG: assert property (@(posedge clk) disable iff (srst)
      (brownout || (bo_flag && !sw_clr_bo)) |=> bo_flag)
      else $error("brownout flag lost without a zero write");

   AST_PIN_WIDTH: assert property (@(posedge clk) disable iff (srst)
      (state == rsm_pkg::RSM_ST_DELAY && cnt == 13'h0000) |-> (!rst_pin_oe_n)[*5])
      else $error("pin released before the minimum output width");

   AST_VECTOR: assert property (@(posedge clk) disable iff (srst)
      (state == rsm_pkg::RSM_ST_FETCH && cnt == 13'h0000)
      |-> fetch_addr == 16'hFFFE ##1 ($past(any_src) || fetch_addr == 16'hFFFF))
      else $error("vector fetch address wrong");

   AST_STAB: assert property (@(posedge clk) disable iff (srst)
      (state == rsm_pkg::RSM_ST_FETCH && $past(state) != rsm_pkg::RSM_ST_FETCH)
      |-> $past(state) == rsm_pkg::RSM_ST_STAB && $past(cnt) == 13'h0FFF)
      else $error("fetch entered without the full stabilisation wait");

   AST_FETCH2: assert property (@(posedge clk) disable iff (srst)
      (state == rsm_pkg::RSM_ST_FETCH && cnt == 13'h0000 && !any_src) ##1 !any_src
      |=> state == rsm_pkg::RSM_ST_RUN && !core_reset)
      else $error("fetch phase not exactly two cycles");

   AST_EXT: assert property (@(posedge clk) disable iff (srst)
      (ext_seen && !pin_drive && !drive_d1) |=> state == rsm_pkg::RSM_ST_DELAY)
      else $error("external pulse not turned into a reset");

   AST_WDG_FLAG: assert property (@(posedge clk) disable iff (srst)
      (brownout && !wdg_underflow) |=> !wdg_flag)
      else $error("watchdog flag not cleared by brownout");

   AST_RESTART: assert property (@(posedge clk) disable iff (srst)
      (any_src && state != rsm_pkg::RSM_ST_DELAY) |=> pin_drive && cnt == 13'h0000)
      else $error("new source did not restart the sequence");

   AST_WDG_SET: assert property (@(posedge clk) disable iff (srst)
      wdg_underflow |=> wdg_flag && !rst_pin_oe_n && cnt == 13'h0000)
      else $error("watchdog underflow did not restart with the pin low");

   AST_OSC_OPT: assert property (@(posedge clk) disable iff (srst)
      (wr_option && wr.strb[0]) |=> osc_select == $past(wr.data[`RSM_OPT_OSC_LSB +: 3]))
      else $error("oscillator option not applied");

   AST_CSS_OPT: assert property (@(posedge clk) disable iff (srst)
      (wr_option && wr.strb[1]) |=> css_enable == $past(wr.data[`RSM_OPT_CSS_BIT]))
      else $error("clock safety option not applied");
endmodule

// *** rsm_regs.svh ***
// Register map, field positions, reset values and timing counts of the reset manager
`ifndef RSM_REGS_SVH
`define RSM_REGS_SVH
// Register byte offsets
`define RSM_ADDR_FLAGS 8'h00
`define RSM_ADDR_OPTION 8'h04
`define RSM_ADDR_STATE 8'h08
// Field positions
`define RSM_BIT_WDG 0
`define RSM_BIT_BO 4
`define RSM_OPT_OSC_LSB 0
`define RSM_OPT_LVL_LSB 4
`define RSM_OPT_CSS_BIT 8
// Reset values: first crystal range, lowest detector level, clock safety on
`define RSM_OPT_OSC_RST 3'h1
`define RSM_OPT_LVL_RST 2'h0
`define RSM_OPT_CSS_RST 1'h1
// Bus responses
`define RSM_RESP_OKAY 2'h0
`define RSM_RESP_SLVERR 2'h2
// Timing
`define RSM_CLK_PERIOD_NS 100
`define RSM_T_RSTL_OUT_NS 500
`define RSM_RSTL_OUT_CYC ((`RSM_T_RSTL_OUT_NS + `RSM_CLK_PERIOD_NS - 1) / `RSM_CLK_PERIOD_NS)
`define RSM_STAB_CYC 4096
`define RSM_FETCH_CYC 2
`define RSM_VECTOR_ADDR 16'hFFFE
// Detector thresholds per level: rising and falling supply codes
`define RSM_LVD_RISE0 8'h90
`define RSM_LVD_FALL0 8'h88
`define RSM_LVD_RISE1 8'hA0
`define RSM_LVD_FALL1 8'h98
`define RSM_LVD_RISE2 8'hB0
`define RSM_LVD_FALL2 8'hA8
`endif

// *** rsm_pkg.sv ***
// Types shared by the reset manager files
package rsm_pkg;
   typedef enum logic [1:0] {
      RSM_ST_DELAY = 2'b00,
      RSM_ST_STAB = 2'b01,
      RSM_ST_FETCH = 2'b10,
      RSM_ST_RUN = 2'b11
   } rsm_state_t;
   typedef enum logic [2:0] {
      RSM_OSC_EXT = 3'b000,
      RSM_OSC_XTAL0 = 3'b001,
      RSM_OSC_XTAL1 = 3'b010,
      RSM_OSC_XTAL2 = 3'b011,
      RSM_OSC_XTAL3 = 3'b100,
      RSM_OSC_ERC = 3'b101,
      RSM_OSC_IRC = 3'b110
   } rsm_osc_t;
   typedef enum logic [1:0] {
      RSM_LVL_LOW = 2'b00,
      RSM_LVL_MID = 2'b01,
      RSM_LVL_HIGH = 2'b10
   } rsm_lvd_level_t;
   typedef struct packed {
      logic awvalid; logic [7:0] awaddr;
      logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
      logic bready;
      logic arvalid; logic [7:0] araddr;
      logic rready;
   } rsm_axil_req_t;
   typedef struct packed {
      logic awready; logic wready;
      logic bvalid; logic [1:0] bresp;
      logic arready;
      logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
   } rsm_axil_rsp_t;
   typedef struct packed {
      logic en; logic [7:0] addr; logic [31:0] data; logic [3:0] strb;
   } rsm_reg_wr_t;
endpackage

// *** rsm_lvd.sv ***
// Supply comparator with selectable level and rise/fall hysteresis
`timescale 1ns/100ps
`include "rsm_regs.svh"
module rsm_lvd (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Supply sense and level option
   input wire logic [7:0] vdd_level,
   input wire rsm_pkg::rsm_lvd_level_t level,
   // Detector result
   output logic brownout
);
   logic [7:0] rise;
   logic [7:0] fall;
   logic next_brownout;

   // Higher release point than trip point avoids reset chatter on load steps
   always_comb begin
      case (level)
         rsm_pkg::RSM_LVL_LOW: begin rise = `RSM_LVD_RISE0; fall = `RSM_LVD_FALL0; end
         rsm_pkg::RSM_LVL_MID: begin rise = `RSM_LVD_RISE1; fall = `RSM_LVD_FALL1; end
         default: begin rise = `RSM_LVD_RISE2; fall = `RSM_LVD_FALL2; end
      endcase
      next_brownout = brownout ? (vdd_level < rise) : (vdd_level < fall);
   end

   // Starts tripped so power-up is always covered
   always_ff @(posedge clk) begin
      if (srst) brownout <= 1'b1;
      else brownout <= next_brownout;
   end

   AST_LVD_RELEASE: assert property (@(posedge clk) disable iff (srst)
      (brownout && vdd_level >= rise) |=> !brownout)
      else $error("detector did not release above rising point");
   AST_LVD_TRIP: assert property (@(posedge clk) disable iff (srst)
      (!brownout && vdd_level < fall) |=> brownout)
      else $error("detector did not trip below falling point");
endmodule

// *** rsm_axil.sv ***
// AXI4-Lite slave front end turning bus beats into register strobes
`timescale 1ns/100ps
`include "rsm_regs.svh"
module rsm_axil (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bus
   input wire rsm_pkg::rsm_axil_req_t req,
   output rsm_pkg::rsm_axil_rsp_t rsp,
   // Register side
   output rsm_pkg::rsm_reg_wr_t wr,
   input wire logic wr_ok,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_held, w_held, bvalid, rvalid;
   logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data, rdata, next_rdata;
   logic [3:0] w_strb, next_w_strb;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic do_wr;

   // Address and data may arrive in either order; both wait until paired
   always_comb begin
      rsp.awready = !aw_held && !bvalid;
      rsp.wready = !w_held && !bvalid;
      rsp.bvalid = bvalid;
      rsp.bresp = bresp;
      rsp.arready = !rvalid;
      rsp.rvalid = rvalid;
      rsp.rdata = rdata;
      rsp.rresp = rresp;
      do_wr = aw_held && w_held && !bvalid;
      wr.en = do_wr;
      wr.addr = aw_addr;
      wr.data = w_data;
      wr.strb = w_strb;
      rd_addr = req.araddr;
   end

   // Next bus state
   always_comb begin
      next_aw_held = aw_held; next_aw_addr = aw_addr;
      next_w_held = w_held; next_w_data = w_data; next_w_strb = w_strb;
      next_bvalid = bvalid; next_bresp = bresp;
      next_rvalid = rvalid; next_rdata = rdata; next_rresp = rresp;
      if (req.awvalid && rsp.awready) begin
         next_aw_held = 1'b1; next_aw_addr = req.awaddr;
      end
      if (req.wvalid && rsp.wready) begin
         next_w_held = 1'b1; next_w_data = req.wdata; next_w_strb = req.wstrb;
      end
      if (do_wr) begin
         next_aw_held = 1'b0; next_w_held = 1'b0; next_bvalid = 1'b1;
         next_bresp = wr_ok ? `RSM_RESP_OKAY : `RSM_RESP_SLVERR;
      end else if (bvalid && req.bready) next_bvalid = 1'b0;
      if (req.arvalid && rsp.arready) begin
         next_rvalid = 1'b1;
         next_rdata = rd_ok ? rd_data : 32'h0000_0000;
         next_rresp = rd_ok ? `RSM_RESP_OKAY : `RSM_RESP_SLVERR;
      end else if (rvalid && req.rready) next_rvalid = 1'b0;
   end

   // Bus state registers
   always_ff @(posedge clk) begin
      if (srst) begin
         aw_held <= 1'b0; aw_addr <= 8'h00; w_held <= 1'b0;
         w_data <= 32'h0000_0000; w_strb <= 4'h0;
         bvalid <= 1'b0; bresp <= 2'h0;
         rvalid <= 1'b0; rdata <= 32'h0000_0000; rresp <= 2'h0;
      end else begin
         aw_held <= next_aw_held; aw_addr <= next_aw_addr; w_held <= next_w_held;
         w_data <= next_w_data; w_strb <= next_w_strb;
         bvalid <= next_bvalid; bresp <= next_bresp;
         rvalid <= next_rvalid; rdata <= next_rdata; rresp <= next_rresp;
      end
   end
endmodule

// *** rsm_board_model.sv ***
// Board side of the reset pin: pull-up, wired-low drive and an external reset switch
`timescale 1ns/100ps
module rsm_board_model (
   // Device pin drive
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe_n,
   // External reset request from the board
   input wire logic ext_low,
   // Resolved pin level
   output logic rst_pin
);
   // Open drain wired-low, weak pull-up otherwise
   assign rst_pin = ((!rst_pin_oe_n && !rst_pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule

// *** rsm_reset_sequence_manager_bench.sv ***
// Self-checking bench of the reset manager: bus tasks and reset sequence scenarios
`timescale 1ns/100ps
module rsm_reset_sequence_manager_bench;
   logic clk;
   logic srst;
   rsm_pkg::rsm_axil_req_t req;
   rsm_pkg::rsm_axil_rsp_t rsp;
   logic [7:0] vdd;
   logic wdg;
   logic ext_low;
   logic pin;
   logic pin_out;
   logic pin_oe_n;
   logic core_reset;
   logic vector_fetch;
   logic [15:0] fetch_addr;
   rsm_pkg::rsm_osc_t osc_select;
   logic osc_run;
   logic css_enable;
   logic brownout;
   logic xtal_exp;
   logic [31:0] d;
   logic [1:0] r;
   int miscompares;
   int cmp_count;

   rsm_reset_sequence_manager dut (.clk(clk), .srst(srst), .axil_req(req), .axil_rsp(rsp),
      .vdd_level(vdd), .wdg_underflow(wdg), .rst_pin_in(pin), .rst_pin_out(pin_out),
      .rst_pin_oe_n(pin_oe_n), .core_reset(core_reset), .vector_fetch(vector_fetch),
      .fetch_addr(fetch_addr), .osc_select(osc_select), .osc_run(osc_run),
      .css_enable(css_enable), .brownout(brownout));
   rsm_board_model board (.rst_pin_out(pin_out), .rst_pin_oe_n(pin_oe_n), .ext_low(ext_low),
      .rst_pin(pin));

   // Clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Bus write; readiness is sampled at the falling edge so it is settled
   task automatic axw(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
      bit aw;
      bit w;
      bit aw_hs;
      bit w_hs;
      aw = 0;
      w = 0;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= dat;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      while (!(aw && w)) begin
         @(negedge clk);
         aw_hs = !aw && rsp.awready;
         w_hs = !w && rsp.wready;
         @(posedge clk);
         if (aw_hs) req.awvalid <= 1'b0;
         if (w_hs) req.wvalid <= 1'b0;
         aw |= aw_hs;
         w |= w_hs;
      end
      @(negedge clk);
      while (rsp.bvalid !== 1'b1) @(negedge clk);
      resp = rsp.bresp;
      @(posedge clk);
      req.bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      @(negedge clk);
      while (rsp.arready !== 1'b1) @(negedge clk);
      @(posedge clk);
      req.arvalid <= 1'b0;
      @(negedge clk);
      while (rsp.rvalid !== 1'b1) @(negedge clk);
      dat = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clk);
      req.rready <= 1'b0;
   endtask

   task automatic wdg_pulse();
      @(posedge clk);
      wdg <= 1'b1;
      @(posedge clk);
      wdg <= 1'b0;
   endtask

   // Follows one reset sequence from the pin drive to execution start
   task automatic seq_check();
      int n;
      n = 0;
      @(negedge clk);
      // A pin source shows up one edge late; wait for the device drive
      while (pin_oe_n !== 1'b0 && n < 20) begin
         n++;
         @(negedge clk);
      end
      n = 0;
      chk(osc_run, xtal_exp);
      while (pin_oe_n === 1'b0) begin
         n++;
         @(negedge clk);
      end
      chk(n >= 5, 1);
      n = 0;
      while (pin_oe_n === 1'b1 && vector_fetch !== 1'b1 && n < 5000) begin
         n++;
         @(negedge clk);
      end
      chk(n, 4096);
      chk({vector_fetch, fetch_addr}, {1'b1, 16'hFFFE});
      @(negedge clk);
      chk({vector_fetch, fetch_addr}, {1'b1, 16'hFFFF});
      @(negedge clk);
      chk({vector_fetch, core_reset}, 0);
   endtask

   // Hang guard, about two and a half times the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      end_sim();
   end

   initial begin
      miscompares = 0;
      cmp_count = 0;
      req = '0;
      srst = 1'b1;
      vdd = 8'h80;
      wdg = 1'b0;
      ext_low = 1'b0;
      xtal_exp = 1'b1;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      // Supply low after reset: device holds itself and the board in reset
      repeat (20) @(negedge clk);
      chk({pin_oe_n, core_reset, brownout}, 3'h3);
      chk(pin, 0);
      chk({osc_select, css_enable}, 4'h3);
      @(posedge clk);
      vdd <= 8'h8C;
      repeat (20) @(negedge clk);
      chk(pin_oe_n, 0);
      @(posedge clk);
      vdd <= 8'h90;
      seq_check();
      chk({pin, pin_out}, 2'h2);
      axr(8'h00, d, r);
      chk(d, 32'h10);
      axw(8'h00, 32'h10, r);
      axr(8'h00, d, r);
      chk(d, 32'h10);
      // Watchdog reset keeps the brownout flag
      wdg_pulse();
      seq_check();
      axr(8'h00, d, r);
      chk(d, 32'h11);
      axw(8'h00, 32'h10, r);
      axr(8'h00, d, r);
      chk(d, 32'h10);
      axw(8'h00, 32'h00, r);
      axr(8'h00, d, r);
      chk(d, 32'h00);
      // External pulse of three cycles, shorter than the minimum output width
      @(posedge clk);
      ext_low <= 1'b1;
      fork
         begin
            repeat (3) @(posedge clk);
            ext_low <= 1'b0;
         end
      join_none
      seq_check();
      axr(8'h00, d, r);
      chk(d, 32'h00);
      // Second watchdog reset in the stabilisation phase restarts it in full
      wdg_pulse();
      @(negedge clk);
      while (pin_oe_n !== 1'b1) @(negedge clk);
      repeat (100) @(negedge clk);
      wdg_pulse();
      seq_check();
      // Higher detector level trips at the present supply and clears the watchdog flag
      axw(8'h04, 32'h111, r);
      repeat (3) @(negedge clk);
      chk({brownout, pin_oe_n}, 2'h2);
      axr(8'h00, d, r);
      chk(d, 32'h10);
      @(posedge clk);
      vdd <= 8'hA0;
      seq_check();
      // Every oscillator code, alternating clock safety enable
      for (int i = 0; i < 7; i++) begin
         axw(8'h04, 32'h10 | i | ((i & 1) << 8), r);
         @(negedge clk);
         chk({osc_select, css_enable}, {i[2:0], i[0]});
      end
      // Internal RC may stop while the pin is driven
      xtal_exp = 1'b0;
      wdg_pulse();
      seq_check();
      axr(8'h08, d, r);
      chk({r, d}, {2'h0, 32'h3});
      axr(8'h0C, d, r);
      chk({r, d}, {2'h2, 32'h0});
      axw(8'h0C, 32'h0, r);
      chk(r, 2'h2);
      end_sim();
   end
endmodule
